// ---- design/hfq_pkg.sv ----
// Constants, register map and encodings for the frame queue manager.
// Assumes every user refers to names as hfq_pkg::name.
package hfq_pkg;

    // ------------------------------------------------------------
    // Register addresses on the host bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] A_CFG = 4'h0;
    localparam logic [3:0] A_TXTAG = 4'h1;
    localparam logic [3:0] A_TXFILL = 4'h2;
    localparam logic [3:0] A_DATA = 4'h3;
    localparam logic [3:0] A_RXQ = 4'h4;
    localparam logic [3:0] A_RXLVL = 4'h5;
    localparam logic [3:0] A_CTRL = 4'h6;
    localparam logic [3:0] A_IEN = 4'he;
    localparam logic [3:0] A_ISTS = 4'hf;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int B_FILLFLAG = 2;
    localparam int B_TX_RESET = 5;
    localparam int B_RX_RESET = 4;
    localparam int EV_TX_DONE = 0;
    localparam int EV_TLVL = 1;
    localparam int EV_UND = 2;
    localparam int EV_RLVL = 3;
    localparam int EV_EOF = 4;
    localparam int EV_OVR = 5;

    // Status byte masks
    localparam logic [7:0] STAT_CRC_M = 8'h80;
    localparam logic [7:0] STAT_ABT_M = 8'h40;
    localparam logic [7:0] STAT_OVR_M = 8'h20;
    localparam logic [7:0] STAT_CNT_M = 8'h10;

    // Reset values and sizes
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [5:0] LVL_RST = 6'h00;
    localparam int FIFO_AW = 6;
    localparam int HOLD_BYTES = 2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        K_ONES = 3'h0,
        K_FLAG = 3'h1,
        K_DATA = 3'h2,
        K_LAST = 3'h3,
        K_ABORT = 3'h4
    } hfq_kind_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_FRAME = 2'h1,
        TX_FORCED = 2'h2,
        TX_STUCK = 2'h3
    } hfq_tx_st_t;

endpackage

// ---- design/hfq_fifo_if.sv ----
// Connection bundle between the queue manager and one byte store.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface hfq_fifo_if #(parameter int W = 10, parameter int AW = 6);
    logic push;
    logic pop;
    logic flush;
    logic ovwr;
    logic tag_set;
    logic [1:0] tag;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic [AW:0] count;
    logic [AW:0] mark_dist;
    logic mark_found;
    logic empty;
    logic full;

    modport store (input push, pop, flush, ovwr, tag_set, tag, wdata,
                   output rdata, count, mark_dist, mark_found, empty, full);
    modport user (output push, pop, flush, ovwr, tag_set, tag, wdata,
                  input rdata, count, mark_dist, mark_found, empty, full);
endinterface

// ---- design/hfq_fifo.sv ----
// Ring store with overwrite of the newest entry, tagging of the newest
// entry and a search for the first marked entry (top bit of a word).
// Assumes depth is a power of two.
`timescale 1ns/1ps
module hfq_fifo #(
    parameter int W = 10,
    parameter int AW = 6
) (
    input wire logic sys_clk, // Device clock
    input wire logic nrst, // Asynchronous reset, active low
    hfq_fifo_if.store f // Store side of the bundle
);
    localparam int DEPTH = 1 << AW;

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic [AW-1:0] last_w;
    logic do_push;
    logic do_pop;

    // Status and strobes
    assign f.empty = (cnt_q == '0);
    assign f.full = (cnt_q == (AW+1)'(DEPTH));
    assign f.count = cnt_q;
    assign f.rdata = mem_q[rd_q];
    assign do_push = f.push && !f.full;
    assign do_pop = f.pop && !f.empty;
    assign last_w = wr_q - AW'(1);

    // Storage: push, else overwrite newest, else tag newest once
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem_q[wr_q] <= f.wdata;
        end else if (f.ovwr && !f.empty) begin
            mem_q[last_w] <= f.wdata;
        end else if (f.tag_set && !f.empty && mem_q[last_w][W-1 -: 2] == 2'h0) begin
            mem_q[last_w][W-1 -: 2] <= f.tag;
        end
    end

    // Pointers and fill count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (f.flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(do_push);
            rd_q <= rd_q + AW'(do_pop);
            cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // Distance from the read side to the first marked word
    always_comb begin
        logic [AW-1:0] idx;
        idx = '0;
        f.mark_found = 1'b0;
        f.mark_dist = '0;
        for (int i = 0; i < DEPTH; i++) begin
            idx = rd_q + AW'(i);
            if (!f.mark_found && (AW+1)'(i) < cnt_q && mem_q[idx][W-1]) begin
                f.mark_found = 1'b1;
                f.mark_dist = (AW+1)'(i + 1);
            end
        end
    end
endmodule // hfq_fifo

// ---- design/hfq_crc_holdback.sv ----
// Holds back the newest received bytes so that the two check bytes
// before a closing flag or abort never reach the queue.
// Assumes the framer marks a frame end with one pulse.
`timescale 1ns/1ps
module hfq_crc_holdback #(
    parameter int HOLD = 2
) (
    input wire logic sys_clk, // Device clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic flush, // Drop held bytes
    input wire logic in_valid, // Byte from framer
    input wire logic [7:0] in_byte, // Byte value
    input wire logic frame_end, // Frame closed or aborted
    output logic out_valid, // Released byte strobe
    output logic [7:0] out_byte // Released byte, from flops
);
    logic [7:0] hold_q [HOLD];
    logic [$clog2(HOLD+1)-1:0] fill_q;
    logic full_w;

    // Oldest held byte leaves when a new one enters a full holdback
    assign full_w = (fill_q == $bits(fill_q)'(HOLD));
    assign out_valid = in_valid && !frame_end && full_w;
    assign out_byte = hold_q[HOLD-1];

    // Shift chain; a frame end discards what is held
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            fill_q <= '0;
            for (int i = 0; i < HOLD; i++) hold_q[i] <= 8'h00;
        end else if (flush || frame_end) begin
            fill_q <= '0;
        end else if (in_valid) begin
            hold_q[0] <= in_byte;
            for (int i = 1; i < HOLD; i++) hold_q[i] <= hold_q[i-1];
            if (!full_w) fill_q <= fill_q + $bits(fill_q)'(1);
        end
    end
endmodule // hfq_crc_holdback

// ---- design/hfq_queue_mgr.sv ----
// Queue manager for the transmit and receive byte queues of a serial
// frame transceiver: host registers on one side, framer on the other.
// Assumes a framer that asks for one byte per tx_req and hands in
// destuffed bytes with a frame-end pulse carrying the frame's errors.
`timescale 1ns/1ps
module hfq_queue_mgr #(
    parameter int FIFO_AW = hfq_pkg::FIFO_AW
) (
    input wire logic sys_clk, // Device clock, 25 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic [3:0] bus_addr, // Register address
    input wire logic bus_wr, // Write strobe, one cycle
    input wire logic bus_rd, // Read strobe, one cycle
    input wire logic [7:0] bus_wdata, // Write data
    output logic [7:0] bus_rdata, // Read data, cycle after bus_rd
    output logic int_n, // Interrupt, active low
    input wire logic tx_req, // Framer asks for next byte
    output logic tx_ack, // Answer to tx_req
    output logic [7:0] tx_data, // Byte to send
    output logic [2:0] tx_kind, // What to send, hfq_kind_t
    input wire logic rx_valid, // Received byte strobe
    input wire logic [7:0] rx_byte, // Received byte
    input wire logic rx_end, // Frame closed or aborted
    input wire logic rx_crc_bad, // Check mismatch, with rx_end
    input wire logic rx_abort, // Abort seen, with rx_end
    input wire logic rx_bad_count // Bits not a byte multiple
);
    localparam logic [FIFO_AW:0] DEPTH_C = (FIFO_AW+1)'(1 << FIFO_AW);

    hfq_fifo_if #(.W(10), .AW(FIFO_AW)) txf ();
    hfq_fifo_if #(.W(9), .AW(FIFO_AW)) rxf ();

    hfq_pkg::hfq_tx_st_t st_q, st_d;
    hfq_pkg::hfq_kind_t kind_q, kind_d, fill_kind;
    logic [7:0] cfg_q, ien_q, ists_q, ists_d, ev, rd_mux, rdata_q, data_q, data_d, stat_byte;
    logic [5:0] tx_lvl_q, rx_lvl_q;
    logic [FIFO_AW:0] tx_free, rx_qcount;
    logic tx_ack_q, tx_pop, done_ev, und_ev, live_q, rhit_q, tx_live, rhit;
    logic wr_cfg, wr_tag, wr_data, wr_rlvl, wr_ctrl, wr_ien, rd_ists, rd_data;
    logic tx_reset_bit, rx_reset_bit, chip_rst, tx_rst, rx_rst;
    logic lock_q, lsts_q, lbyte_q, lock_done, end_ok, wr_want, hb_valid;
    logic [7:0] hb_byte;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Strobes per register
    assign wr_cfg = bus_wr && bus_addr == hfq_pkg::A_CFG;
    assign wr_tag = bus_wr && bus_addr == hfq_pkg::A_TXTAG;
    assign wr_data = bus_wr && bus_addr == hfq_pkg::A_DATA;
    assign wr_rlvl = bus_wr && bus_addr == hfq_pkg::A_RXLVL;
    assign wr_ctrl = bus_wr && bus_addr == hfq_pkg::A_CTRL;
    assign wr_ien = bus_wr && bus_addr == hfq_pkg::A_IEN;
    assign rd_ists = bus_rd && bus_addr == hfq_pkg::A_ISTS;
    assign rd_data = bus_rd && bus_addr == hfq_pkg::A_DATA;

    // Soft resets: both bits at once also clear the registers and event status
    assign tx_reset_bit = wr_ctrl && bus_wdata[hfq_pkg::B_TX_RESET];
    assign rx_reset_bit = wr_ctrl && bus_wdata[hfq_pkg::B_RX_RESET];
    assign chip_rst = tx_reset_bit && rx_reset_bit;
    assign tx_rst = tx_reset_bit;
    assign rx_rst = rx_reset_bit;

    // Configuration and enable registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= hfq_pkg::REG_RST;
            ien_q <= hfq_pkg::REG_RST;
            tx_lvl_q <= hfq_pkg::LVL_RST;
            rx_lvl_q <= hfq_pkg::LVL_RST;
        end else if (chip_rst) begin
            cfg_q <= hfq_pkg::REG_RST;
            ien_q <= hfq_pkg::REG_RST;
            tx_lvl_q <= hfq_pkg::LVL_RST;
            rx_lvl_q <= hfq_pkg::LVL_RST;
        end else begin
            if (wr_cfg) cfg_q <= bus_wdata;
            if (wr_ien) ien_q <= bus_wdata;
            if (wr_tag) tx_lvl_q <= bus_wdata[5:0];
            if (wr_rlvl) rx_lvl_q <= bus_wdata[5:0];
        end
    end

    // ------------------------------------------------------------
    // Transmit queue
    // ------------------------------------------------------------
    hfq_fifo #(.W(10), .AW(FIFO_AW)) u_txq (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .f(txf)
    );

    // Tag bits ride above the data byte: complete high, abort low
    assign txf.push = wr_data;
    assign txf.wdata = {2'h0, bus_wdata};
    assign txf.tag_set = wr_tag;
    assign txf.tag = bus_wdata[7:6];
    assign txf.pop = tx_pop;
    assign txf.flush = tx_rst;
    assign txf.ovwr = 1'b0;

    // Free slots and live level
    assign tx_free = DEPTH_C - txf.count;
    assign tx_live = tx_free <= (FIFO_AW+1)'(tx_lvl_q);
    assign fill_kind = cfg_q[hfq_pkg::B_FILLFLAG] ? hfq_pkg::K_FLAG : hfq_pkg::K_ONES;

    // Byte sequencer toward the framer
    always_comb begin
        st_d = st_q;
        kind_d = fill_kind;
        data_d = 8'hff;
        tx_pop = 1'b0;
        done_ev = 1'b0;
        und_ev = 1'b0;
        if (tx_req) begin
            unique case (st_q)
                hfq_pkg::TX_IDLE, hfq_pkg::TX_FRAME: begin
                    if (!txf.empty) begin
                        tx_pop = 1'b1;
                        data_d = txf.rdata[7:0];
                        unique case (txf.rdata[9:8])
                            2'h0: begin
                                kind_d = hfq_pkg::K_DATA;
                                st_d = hfq_pkg::TX_FRAME;
                            end
                            2'h2: begin
                                kind_d = hfq_pkg::K_LAST;
                                done_ev = 1'b1;
                                st_d = hfq_pkg::TX_IDLE;
                            end
                            2'h1: begin
                                kind_d = hfq_pkg::K_ABORT;
                                done_ev = 1'b1;
                                st_d = hfq_pkg::TX_IDLE;
                            end
                            2'h3: st_d = hfq_pkg::TX_STUCK;
                        endcase
                    end else if (st_q == hfq_pkg::TX_FRAME) begin
                        kind_d = hfq_pkg::K_ABORT;
                        done_ev = 1'b1;
                        und_ev = 1'b1;
                        st_d = hfq_pkg::TX_FORCED;
                    end
                end
                hfq_pkg::TX_FORCED, hfq_pkg::TX_STUCK: st_d = st_q;
            endcase
        end
        if (st_q == hfq_pkg::TX_FORCED && rd_ists) st_d = hfq_pkg::TX_IDLE;
    end

    // Sequencer state and answer flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= hfq_pkg::TX_IDLE;
            tx_ack_q <= 1'b0;
            kind_q <= hfq_pkg::K_ONES;
            data_q <= 8'hff;
        end else begin
            st_q <= tx_rst ? hfq_pkg::TX_IDLE : st_d;
            tx_ack_q <= tx_req;
            if (tx_req) begin
                kind_q <= kind_d;
                data_q <= data_d;
            end
        end
    end

    assign tx_ack = tx_ack_q;
    assign tx_data = data_q;
    assign tx_kind = kind_q;

    // ------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------
    hfq_crc_holdback #(.HOLD(hfq_pkg::HOLD_BYTES)) u_hold (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .flush(rx_rst),
        .in_valid(rx_valid && !lock_q),
        .in_byte(rx_byte),
        .frame_end(rx_end),
        .out_valid(hb_valid),
        .out_byte(hb_byte)
    );

    hfq_fifo #(.W(9), .AW(FIFO_AW)) u_rxq (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .f(rxf)
    );

    // Status byte and store control
    assign stat_byte = (rx_crc_bad ? hfq_pkg::STAT_CRC_M : 8'h00)
                   | (rx_abort ? hfq_pkg::STAT_ABT_M : 8'h00)
                   | (rx_bad_count ? hfq_pkg::STAT_CNT_M : 8'h00);
    assign end_ok = rx_end && !lock_q;
    assign wr_want = end_ok || hb_valid;
    assign rxf.push = wr_want && !rxf.full;
    assign rxf.ovwr = wr_want && rxf.full;
    assign rxf.wdata = rxf.full ? {1'b1, (end_ok ? stat_byte : 8'h00) | hfq_pkg::STAT_OVR_M}
                                : {end_ok, end_ok ? stat_byte : hb_byte};
    assign rxf.pop = rd_data;
    assign rxf.flush = rx_rst;
    assign rxf.tag_set = 1'b0;
    assign rxf.tag = 2'h0;

    // Count to first status byte, else bytes present
    assign rx_qcount = rxf.mark_found ? rxf.mark_dist : rxf.count;
    assign rhit = rx_lvl_q != 6'h00 && rxf.count >= (FIFO_AW+1)'(rx_lvl_q);

    // Overrun lock: needs a status read and a data read
    assign lock_done = (lsts_q || rd_ists) && (lbyte_q || (rd_data && !rxf.empty));
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lock_q <= 1'b0;
            lsts_q <= 1'b0;
            lbyte_q <= 1'b0;
        end else if (rx_rst || rxf.ovwr) begin
            lock_q <= rxf.ovwr && !rx_rst;
            lsts_q <= 1'b0;
            lbyte_q <= 1'b0;
        end else if (lock_q) begin
            lock_q <= !lock_done;
            lsts_q <= lsts_q || rd_ists;
            lbyte_q <= lbyte_q || (rd_data && !rxf.empty);
        end
    end

    // ------------------------------------------------------------
    // Event status and interrupt pin
    // ------------------------------------------------------------
    // Events; a new event wins over the read acknowledge
    assign ev = 8'(done_ev) << hfq_pkg::EV_TX_DONE
              | 8'(tx_live && !live_q) << hfq_pkg::EV_TLVL
              | 8'(und_ev) << hfq_pkg::EV_UND
              | 8'(rhit && !rhit_q) << hfq_pkg::EV_RLVL
              | 8'((rxf.push && end_ok) || rxf.ovwr) << hfq_pkg::EV_EOF
              | 8'(rxf.ovwr) << hfq_pkg::EV_OVR;
    assign ists_d = (rd_ists ? 8'h00 : ists_q) | ev;
    assign int_n = ~|(ists_q & ien_q);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ists_q <= hfq_pkg::REG_RST;
            live_q <= 1'b0;
            rhit_q <= 1'b0;
        end else begin
            ists_q <= chip_rst ? hfq_pkg::REG_RST : ists_d;
            live_q <= tx_live;
            rhit_q <= rhit;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_comb begin
        unique case (bus_addr)
            hfq_pkg::A_CFG: rd_mux = cfg_q;
            hfq_pkg::A_TXTAG: rd_mux = {2'h0, tx_lvl_q};
            hfq_pkg::A_TXFILL: rd_mux = {tx_live, 7'(tx_free)};
            hfq_pkg::A_DATA: rd_mux = rxf.rdata[7:0];
            hfq_pkg::A_RXQ: rd_mux = {rxf.mark_found, 7'(rx_qcount)};
            hfq_pkg::A_RXLVL: rd_mux = {2'h0, rx_lvl_q};
            hfq_pkg::A_IEN: rd_mux = ien_q;
            hfq_pkg::A_ISTS: rd_mux = ists_q;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) rdata_q <= 8'h00;
        else rdata_q <= bus_rd ? rd_mux : 8'h00;
    end
    assign bus_rdata = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_underrun_abort: assert property (tx_req && st_q == hfq_pkg::TX_FRAME && txf.empty
        && !tx_rst |=> tx_ack && tx_kind == hfq_pkg::K_ABORT && ists_q[hfq_pkg::EV_UND]
        && st_q == hfq_pkg::TX_FORCED) else $error("underrun not aborted");
    a_forced_fill: assert property (st_q == hfq_pkg::TX_FORCED && tx_req |=>
        tx_kind == (cfg_q[hfq_pkg::B_FILLFLAG] ? hfq_pkg::K_FLAG : hfq_pkg::K_ONES))
        else $error("forced idle sent wrong fill");
    a_forced_hold: assert property (st_q == hfq_pkg::TX_FORCED && !rd_ists && !tx_rst
        |=> st_q == hfq_pkg::TX_FORCED) else $error("forced idle left early");
    a_done_on_end: assert property (tx_ack && (tx_kind == hfq_pkg::K_LAST
        || tx_kind == hfq_pkg::K_ABORT) && !$past(chip_rst) |-> ists_q[hfq_pkg::EV_TX_DONE])
        else $error("done not set at frame end");
    a_fill_read: assert property (bus_rd && bus_addr == hfq_pkg::A_TXFILL |=>
        bus_rdata[6:0] == 7'($past(tx_free)) && bus_rdata[7] == $past(tx_live))
        else $error("fill register mismatch");
    a_eof_event: assert property (end_ok && !rx_rst && !chip_rst |=>
        ists_q[hfq_pkg::EV_EOF]) else $error("frame end not flagged");
    a_eof_pin: assert property (ists_q[hfq_pkg::EV_EOF] && ien_q[hfq_pkg::EV_EOF]
        |-> !int_n) else $error("interrupt pin not driven");
    a_ovr_lock: assert property ((rxf.ovwr || lock_q && !lock_done) && !rx_rst
        |=> lock_q) else $error("overrun lock not held");
    a_rx_empty: assert property (rxf.empty |-> rx_qcount == '0 && !rxf.mark_found)
        else $error("empty queue count not zero");
    a_chip_reset: assert property (chip_rst |=> ien_q == hfq_pkg::REG_RST
        && ists_q == hfq_pkg::REG_RST && cfg_q == hfq_pkg::REG_RST)
        else $error("chip reset incomplete");

    c_underrun: cover property (st_q == hfq_pkg::TX_FRAME ##1 st_q == hfq_pkg::TX_FORCED);
    c_overrun: cover property (rxf.ovwr);
    c_status_pop: cover property (rd_data && rxf.mark_found && rx_qcount == 7'h01);
    c_chip_reset: cover property (chip_rst);
endmodule // hfq_queue_mgr

// ---- tb/hfq_host_model.sv ----
// Host processor model driving the register bus.
// Assumes one-cycle strobes, read data in the cycle after the strobe.
`timescale 1ns/1ps
module hfq_host_model (
    input wire logic sys_clk, // Clock
    output logic [3:0] bus_addr, // Address
    output logic bus_wr, // Write strobe
    output logic bus_rd, // Read strobe
    output logic [7:0] bus_wdata, // Write data
    input wire logic [7:0] bus_rdata // Read data
);
    // Idle bus from time zero
    initial begin
        bus_addr = 4'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        bus_wdata = 8'h00;
    end
    // One write; data inverted after use
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge sys_clk);
        #1 bus_wr = 1'b0;
        bus_wdata = ~d;
    endtask
    // One read, data taken after the strobe edge
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1 bus_addr = a;
        bus_rd = 1'b1;
        @(posedge sys_clk);
        #1 bus_rd = 1'b0;
        d = bus_rdata;
    endtask
endmodule // hfq_host_model

// ---- tb/tb.sv ----
// Bench: host model on the registers, framer driven by hand.
// Assumes the default queue depth.
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic tx_req = 1'b0;
    logic rx_valid = 1'b0;
    logic rx_end = 1'b0;
    logic rx_crc_bad = 1'b0;
    logic rx_abort = 1'b0;
    logic rx_bad_count = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [7:0] rd_v;
    logic [3:0] bus_addr;
    logic bus_wr, bus_rd, int_n, tx_ack;
    logic [7:0] bus_wdata, bus_rdata, tx_data;
    logic [2:0] tx_kind;
    int n_mismatch = 0;
    int samples_checked = 0;
    // Clock, 40 ns period
    always #20 sys_clk = ~sys_clk;
    hfq_host_model host (.sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
    hfq_queue_mgr dut (.sys_clk(sys_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .int_n(int_n),
        .tx_req(tx_req), .tx_ack(tx_ack), .tx_data(tx_data), .tx_kind(tx_kind),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_bad(rx_crc_bad),
        .rx_abort(rx_abort), .rx_bad_count(rx_bad_count));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        host.rd(a, rd_v);
        chk(rd_v, e);
    endtask
    // Framer asks for one symbol; answer seen in the next cycle
    task automatic treq(input logic [2:0] k);
        @(posedge sys_clk);
        #1 tx_req = 1'b1;
        @(posedge sys_clk);
        #1 tx_req = 1'b0;
        chk({4'h0, tx_ack, tx_kind}, {4'h0, 1'b1, k});
    endtask
    // Framer hands in one byte or a frame end; f is {crc bad, abort, bad count}
    task automatic rxin(input logic v, input logic [7:0] b, input logic e, input logic [2:0] f);
        @(posedge sys_clk);
        #1 rx_valid = v;
        rx_byte = b;
        rx_end = e;
        {rx_crc_bad, rx_abort, rx_bad_count} = f;
        @(posedge sys_clk);
        #1 rx_valid = 1'b0;
        rx_end = 1'b0;
        {rx_crc_bad, rx_abort, rx_bad_count} = 3'h0;
        rx_byte = ~b;
    endtask
    task automatic t_tx_frame();
        rdchk(hfq_pkg::A_TXFILL, 8'h40);
        host.wr(hfq_pkg::A_IEN, 8'h01);
        host.wr(hfq_pkg::A_DATA, 8'h5a);
        host.wr(hfq_pkg::A_DATA, 8'ha5);
        host.wr(hfq_pkg::A_TXTAG, 8'hbe);
        rdchk(hfq_pkg::A_TXFILL, 8'hbe);
        host.wr(hfq_pkg::A_TXTAG, 8'h7e);
        treq(hfq_pkg::K_DATA);
        chk(tx_data, 8'h5a);
        treq(hfq_pkg::K_LAST);
        chk(tx_data, 8'ha5);
        chk({7'h00, int_n}, 8'h00);
        rdchk(hfq_pkg::A_ISTS, 8'h03);
        chk({7'h00, int_n}, 8'h01);
    endtask
    task automatic t_underrun();
        host.wr(hfq_pkg::A_CFG, 8'h04);
        host.wr(hfq_pkg::A_DATA, 8'h11);
        treq(hfq_pkg::K_DATA);
        treq(hfq_pkg::K_ABORT);
        chk(tx_data, 8'hff);
        host.wr(hfq_pkg::A_DATA, 8'h22);
        treq(hfq_pkg::K_FLAG);
        rdchk(hfq_pkg::A_ISTS, 8'h05);
        treq(hfq_pkg::K_DATA);
        host.wr(hfq_pkg::A_CTRL, 8'h20);
        host.wr(hfq_pkg::A_CFG, 8'h00);
        treq(hfq_pkg::K_ONES);
    endtask
    task automatic t_rx();
        rxin(1'b1, 8'h31, 1'b0, 3'h0);
        rxin(1'b1, 8'h32, 1'b0, 3'h0);
        rxin(1'b1, 8'h33, 1'b0, 3'h0);
        rxin(1'b0, 8'h00, 1'b1, 3'h4);
        rxin(1'b1, 8'h41, 1'b0, 3'h0);
        rxin(1'b1, 8'h42, 1'b0, 3'h0);
        rxin(1'b0, 8'h00, 1'b1, 3'h3);
        rdchk(hfq_pkg::A_ISTS, 8'h10);
        rdchk(hfq_pkg::A_RXQ, 8'h82);
        rdchk(hfq_pkg::A_DATA, 8'h31);
        rdchk(hfq_pkg::A_RXQ, 8'h81);
        rdchk(hfq_pkg::A_DATA, 8'h80);
        rdchk(hfq_pkg::A_RXQ, 8'h81);
        rdchk(hfq_pkg::A_DATA, 8'h50);
        rdchk(hfq_pkg::A_RXQ, 8'h00);
    endtask
    // Level event with masked service, then a full queue and its lock
    task automatic t_overrun();
        host.wr(hfq_pkg::A_RXLVL, 8'h04);
        host.wr(hfq_pkg::A_IEN, 8'h08);
        for (int i = 0; i < 6; i++) rxin(1'b1, 8'(i), 1'b0, 3'h0);
        @(posedge sys_clk);
        #1 chk({7'h00, int_n}, 8'h00);
        host.wr(hfq_pkg::A_IEN, 8'h00);
        chk({7'h00, int_n}, 8'h01);
        rdchk(hfq_pkg::A_ISTS, 8'h08);
        host.wr(hfq_pkg::A_IEN, 8'h08);
        chk({7'h00, int_n}, 8'h01);
        for (int i = 6; i < 67; i++) rxin(1'b1, 8'(i), 1'b0, 3'h0);
        rxin(1'b1, 8'h77, 1'b0, 3'h0);
        rdchk(hfq_pkg::A_RXQ, 8'hc0);
        rdchk(hfq_pkg::A_ISTS, 8'h30);
        rxin(1'b0, 8'h00, 1'b1, 3'h4);
        rdchk(hfq_pkg::A_DATA, 8'h00);
        rdchk(hfq_pkg::A_RXQ, 8'hbf);
        for (int i = 1; i < 63; i++) rdchk(hfq_pkg::A_DATA, 8'(i));
        rdchk(hfq_pkg::A_DATA, 8'h20);
        rdchk(hfq_pkg::A_RXQ, 8'h00);
    endtask
    task automatic t_reset();
        rxin(1'b0, 8'h00, 1'b1, 3'h0);
        host.wr(hfq_pkg::A_CTRL, 8'h30);
        rdchk(hfq_pkg::A_IEN, 8'h00);
        rdchk(hfq_pkg::A_ISTS, 8'h00);
        rdchk(hfq_pkg::A_RXQ, 8'h00);
    endtask
    task automatic give_verdict();
        $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Reset for two cycles, then every scenario in turn
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 nrst = 1'b1;
        t_tx_frame();
        t_underrun();
        t_rx();
        t_overrun();
        t_reset();
        give_verdict();
    end
    // Watchdog against a hang
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule // tb
